//--- logic/edast_ctrl.sv
// External data move controller: stretch, strobe timing, wait states, addressing.
// Assumes a core sequencer requests moves and freezes while busy_out is high.
`timescale 1ns/100ps
module edast_ctrl (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic move_req_in,
  input wire logic move_write_in,
  input wire logic move_indirect_in,
  input wire logic [7:0] work_reg_in,
  input wire logic [7:0] move_wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] move_rdata_out,
  input wire logic wait_n_in,
  input wire logic [7:0] ext_data_in,
  output logic [7:0] ext_data_out,
  output logic ext_data_oe_out,
  output logic [15:0] ext_addr_out,
  output logic rd_n_out,
  output logic wr_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    edast_pkg::edast_state_e st;
    logic [1:0] phase;
    logic [5:0] clk_left;
    logic [4:0] strobe_left;
    logic strobe_on;
    logic [2:0] stretch;
    logic wait_en;
    logic ptr_sel;
    logic [15:0] dptr0;
    logic [15:0] second_data_pointer;
    logic [7:0] port2;
    logic [1:0] ta_state;
    logic [1:0] ta_mc;
    logic [1:0] ta_phase;
    logic is_write;
    logic [7:0] rdata;
    logic [7:0] mrdata;
    logic busy;
    logic done;
    logic [7:0] dout;
    logic doe;
    logic [15:0] addr;
    logic rd_n;
    logic wr_n;
  } edast_state_s;

  edast_state_s s_q;
  edast_state_s s_d;
  logic [4:0] strobe_clocks;
  logic wait_seen;
  logic [5:0] next_left;

  edast_strobe_width u_width (
    .code_in(s_q.stretch),
    .clocks_out(strobe_clocks)
  );

  // Minimum access length in clocks: stretch plus one machine cycles
  function automatic logic [5:0] access_clocks(input logic [2:0] code);
    access_clocks = {({1'b0, code} + 4'h1), 2'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    wait_seen = 1'b0;
    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        edast_pkg::OFS_CLOCK_CONTROL: begin
          s_d.stretch = reg_wdata_in[edast_pkg::STRETCH_MSB:edast_pkg::STRETCH_LSB];
        end
        edast_pkg::OFS_POINTER_SELECT: begin
          s_d.ptr_sel = reg_wdata_in[0];
        end
        edast_pkg::OFS_DPTR0_LO: begin
          s_d.dptr0[7:0] = reg_wdata_in;
        end
        edast_pkg::OFS_DPTR0_HI: begin
          s_d.dptr0[15:8] = reg_wdata_in;
        end
        edast_pkg::OFS_SECOND_DATA_POINTER_LO: begin
          s_d.second_data_pointer[7:0] = reg_wdata_in;
        end
        edast_pkg::OFS_SECOND_DATA_POINTER_HI: begin
          s_d.second_data_pointer[15:8] = reg_wdata_in;
        end
        edast_pkg::OFS_PORT2: begin
          s_d.port2 = reg_wdata_in;
        end
        edast_pkg::OFS_MEMMAP_CONTROL: begin
          if (s_q.ta_state == 2'h2) begin
            s_d.wait_en = reg_wdata_in[edast_pkg::WAIT_EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // Timed access: 0xaa then 0x55 opens a window of a few machine cycles
    if (s_q.ta_state != 2'h0) begin
      s_d.ta_phase = s_q.ta_phase + 2'h1;
      if (s_q.ta_phase == 2'h3) begin
        if (s_q.ta_mc == 2'h0) begin
          s_d.ta_state = 2'h0;
        end else begin
          s_d.ta_mc = s_q.ta_mc - 2'h1;
        end
      end
    end
    if (reg_wr_in && reg_addr_in == edast_pkg::OFS_TIMED_ACCESS) begin
      s_d.ta_phase = 2'h0;
      s_d.ta_mc = edast_pkg::TA_WINDOW_MC;
      if (reg_wdata_in == edast_pkg::TA_KEY1) begin
        s_d.ta_state = 2'h1;
      end else if (reg_wdata_in == edast_pkg::TA_KEY2 && s_q.ta_state == 2'h1) begin
        s_d.ta_state = 2'h2;
      end else begin
        s_d.ta_state = 2'h0;
      end
    end else if (reg_wr_in && reg_addr_in == edast_pkg::OFS_MEMMAP_CONTROL) begin
      s_d.ta_state = 2'h0;
    end
    // Register reads, data in the following cycle
    if (reg_rd_in) begin
      case (reg_addr_in)
        edast_pkg::OFS_CLOCK_CONTROL: s_d.rdata = {5'h00, s_q.stretch};
        edast_pkg::OFS_POINTER_SELECT: s_d.rdata = {7'h00, s_q.ptr_sel};
        edast_pkg::OFS_MEMMAP_CONTROL: s_d.rdata = {s_q.wait_en, 7'h00};
        edast_pkg::OFS_DPTR0_LO: s_d.rdata = s_q.dptr0[7:0];
        edast_pkg::OFS_DPTR0_HI: s_d.rdata = s_q.dptr0[15:8];
        edast_pkg::OFS_SECOND_DATA_POINTER_LO: s_d.rdata = s_q.second_data_pointer[7:0];
        edast_pkg::OFS_SECOND_DATA_POINTER_HI: s_d.rdata = s_q.second_data_pointer[15:8];
        edast_pkg::OFS_PORT2: s_d.rdata = s_q.port2;
        default: s_d.rdata = 8'h00;
      endcase
    end else begin
      s_d.rdata = 8'h00;
    end

    // Move sequencer
    next_left = 6'h00;
    case (s_q.st)
      edast_pkg::EDAST_IDLE: begin
        s_d.rd_n = 1'b1;
        s_d.wr_n = 1'b1;
        if (move_req_in) begin
          s_d.st = edast_pkg::EDAST_FETCH;
          s_d.phase = 2'h0;
          s_d.busy = 1'b1;
          s_d.is_write = move_write_in;
          if (move_indirect_in) begin
            s_d.addr = {s_q.port2, work_reg_in};
          end else begin
            s_d.addr = s_q.ptr_sel ? s_q.second_data_pointer : s_q.dptr0;
          end
          s_d.dout = move_wdata_in;
        end
      end
      // The fetch cycle is an ordinary four-clock cycle; busy_out is high from its first clock, so the core is frozen through it
      edast_pkg::EDAST_FETCH: begin
        s_d.phase = s_q.phase + 2'h1;
        if (s_q.phase == 2'h3) begin
          s_d.st = edast_pkg::EDAST_ACCESS;
          s_d.clk_left = access_clocks(s_q.stretch);
          // Width is latched so a stretch write mid-move cannot cut the strobe
          s_d.strobe_left = strobe_clocks;
          s_d.strobe_on = 1'b0;
          s_d.doe = s_q.is_write;
        end
      end
      edast_pkg::EDAST_ACCESS: begin
        s_d.phase = s_q.phase + 2'h1;
        next_left = s_q.clk_left - 6'h01;
        // Only the last machine cycle is sampled, so waits never shorten the minimum
        if (s_q.clk_left[5:2] == 4'h0 && s_q.clk_left[1:0] == edast_pkg::SAMPLE_STATE) begin
          wait_seen = s_q.wait_en && !wait_n_in;
        end
        if (wait_seen) begin
          next_left = s_q.clk_left + 6'h03;
        end
        if (s_q.clk_left == 6'h01) begin
          s_d.st = edast_pkg::EDAST_DONE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.strobe_on = 1'b0;
          s_d.rd_n = 1'b1;
          s_d.wr_n = 1'b1;
          s_d.doe = 1'b0;
          if (!s_q.is_write) begin
            s_d.mrdata = ext_data_in;
          end
        end else begin
          s_d.clk_left = next_left;
          // Strobe takes the last clocks of the access and stays low through waits
          if (s_q.strobe_on || next_left <= {1'b0, s_q.strobe_left}) begin
            s_d.strobe_on = 1'b1;
            s_d.rd_n = s_q.is_write;
            s_d.wr_n = !s_q.is_write;
          end
        end
      end
      edast_pkg::EDAST_DONE: begin
        s_d.st = edast_pkg::EDAST_IDLE;
      end
      default: begin
        s_d.st = edast_pkg::EDAST_IDLE;
      end
    endcase
    // Synchronous reset overrides everything above
    if (reset_in) begin
      s_d = '0;
      s_d.st = edast_pkg::EDAST_IDLE;
      s_d.stretch = edast_pkg::STRETCH_RESET;
      s_d.port2 = edast_pkg::PORT2_RESET;
      s_d.rd_n = 1'b1;
      s_d.wr_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata_out = s_q.rdata;
  assign busy_out = s_q.busy;
  assign done_out = s_q.done;
  assign move_rdata_out = s_q.mrdata;
  assign ext_data_out = s_q.dout;
  assign ext_data_oe_out = s_q.doe;
  assign ext_addr_out = s_q.addr;
  assign rd_n_out = s_q.rd_n;
  assign wr_n_out = s_q.wr_n;

  ////////////////////////////////////////////////////////////////////////////
  // Fetch takes exactly four clocks before the access
  a_fetch_four: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (s_q.st == edast_pkg::EDAST_FETCH && s_q.phase == 2'h0) |-> ##3 (s_q.st == edast_pkg::EDAST_FETCH)
      ##1 (s_q.st == edast_pkg::EDAST_ACCESS)
  ) else $error("fetch cycle length wrong");

  a_stretch_field: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == edast_pkg::OFS_CLOCK_CONTROL)
      |=> s_q.stretch == $past(reg_wdata_in[edast_pkg::STRETCH_MSB:edast_pkg::STRETCH_LSB])
  ) else $error("stretch field not loaded");

  a_access_min: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (s_q.st == edast_pkg::EDAST_FETCH && s_q.phase == 2'h3)
      |=> s_q.clk_left == access_clocks($past(s_q.stretch))
  ) else $error("access length wrong");

  a_idle_quiet: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (s_q.st == edast_pkg::EDAST_IDLE) |-> (s_q.rd_n && s_q.wr_n && !s_q.busy)
  ) else $error("strobe or busy outside a move");

  a_done_pulse: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    s_q.done |=> !s_q.done
  ) else $error("done longer than one clock");

  // No disable here: the first clock after reset is the one of interest
  a_stretch_reset: assert property (
    @(posedge ref_clk_in)
    $fell(reset_in) |-> s_q.stretch == edast_pkg::STRETCH_RESET
  ) else $error("stretch reset value wrong");

  a_strobe_one: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !(!s_q.rd_n && !s_q.wr_n)
  ) else $error("both strobes low");

  a_wait_gated: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (s_q.st == edast_pkg::EDAST_ACCESS && !s_q.wait_en) |-> !wait_seen
  ) else $error("wait honoured while disabled");

  a_wait_sample: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    wait_seen |-> (s_q.clk_left == 6'h02 && s_q.strobe_on)
  ) else $error("wait sampled at wrong clock");

  a_wait_extends: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    wait_seen |=> (s_q.st == edast_pkg::EDAST_ACCESS && s_q.clk_left == 6'h05)
  ) else $error("wait did not add a machine cycle");

  a_wait_locked: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == edast_pkg::OFS_MEMMAP_CONTROL && s_q.ta_state != 2'h2)
      |=> $stable(s_q.wait_en)
  ) else $error("wait enable changed without unlock");

  a_indirect_addr: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (s_q.st == edast_pkg::EDAST_IDLE && move_req_in && move_indirect_in)
      |=> s_q.addr == {$past(s_q.port2), $past(work_reg_in)}
  ) else $error("indirect address wrong");

  a_pointer_addr: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (s_q.st == edast_pkg::EDAST_IDLE && move_req_in && !move_indirect_in && s_q.ptr_sel)
      |=> s_q.addr == $past(s_q.second_data_pointer)
  ) else $error("second pointer not used");

  a_strobe_ends: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    (s_q.st == edast_pkg::EDAST_ACCESS && s_q.clk_left == 6'h01) |-> s_q.strobe_on
  ) else $error("strobe not active at access end");

  a_write_data: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    !s_q.wr_n |-> (s_q.doe && $stable(s_q.dout))
  ) else $error("write data not held during strobe");
endmodule

//--- inc/edast_pkg.sv
// Package for the external data move stretch and wait controller.
// Assumes one 125 MHz core clock with a four-clock machine cycle.
package edast_pkg;
  localparam int CLK_PER_MC = 4;
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h8e;
  localparam logic [7:0] OFS_POINTER_SELECT = 8'h86;
  localparam logic [7:0] OFS_MEMMAP_CONTROL = 8'h9c;
  localparam logic [7:0] OFS_TIMED_ACCESS = 8'hc7;
  localparam logic [7:0] OFS_DPTR0_LO = 8'h82;
  localparam logic [7:0] OFS_DPTR0_HI = 8'h83;
  localparam logic [7:0] OFS_SECOND_DATA_POINTER_LO = 8'h84;
  localparam logic [7:0] OFS_SECOND_DATA_POINTER_HI = 8'h85;
  localparam logic [7:0] OFS_PORT2 = 8'ha0;
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_MSB = 2;
  localparam int WAIT_EN_BIT = 7;
  localparam logic [2:0] STRETCH_RESET = 3'h1;
  localparam logic [7:0] PORT2_RESET = 8'hff;
  localparam logic [7:0] TA_KEY1 = 8'haa;
  localparam logic [7:0] TA_KEY2 = 8'h55;
  localparam logic [1:0] TA_WINDOW_MC = 2'h3;
  // Clock state at which wait is sampled (third of four)
  localparam logic [1:0] SAMPLE_STATE = 2'h2;
  typedef enum logic [3:0] {
    EDAST_IDLE = 4'h1,
    EDAST_FETCH = 4'h2,
    EDAST_ACCESS = 4'h4,
    EDAST_DONE = 4'h8
  } edast_state_e;
endpackage

//--- logic/edast_strobe_width.sv
// Strobe width lookup for a stretch code.
// Assumes codes come straight from the stretch field.
`timescale 1ns/100ps
module edast_strobe_width (
  input wire logic [2:0] code_in,
  output logic [4:0] clocks_out
);
  always_comb begin
    if (code_in == 3'h0) begin
      clocks_out = 5'h02;
    end else begin
      clocks_out = {code_in, 2'h0};
    end
  end
endmodule

//--- test/edast_ext_mem.sv
// External data memory model for the move controller bench.
// Assumes active-low strobes, an active-low wait line and byte-wide data.
`timescale 1ns/100ps
module edast_ext_mem (
  input wire logic clk_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic [3:0] wait_mc_in,
  output logic [7:0] data_out,
  output logic wait_n_out
);
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  int cnt = 0;
  always @(posedge clk_in) begin
    if (!wr_n_in) mem[addr_in[7:0]] <= data_in;
    if (!rd_n_in) last <= mem[addr_in[7:0]];
    cnt <= (rd_n_in && wr_n_in) ? 0 : cnt + 1;
  end
  // Wait held low until the slow device is ready
  assign wait_n_out = !((!rd_n_in || !wr_n_in) && cnt < 4 * wait_mc_in);
  // Released bus shows the inverse so a stale value never passes
  assign data_out = rd_n_in ? ~last : mem[addr_in[7:0]];
endmodule

//--- test/test_ext_data_access_stretch_wait.sv
// Self-checking bench for the external data move controller.
// Assumes busy_out spans the whole move and done_out pulses at its end.
`timescale 1ns/100ps
module test_ext_data_access_stretch_wait;
  logic ref_clk_in, reset_in, reg_wr_in, reg_rd_in, move_req_in, move_write_in, move_indirect_in, wait_n_in;
  logic [7:0] reg_addr_in, reg_wdata_in, work_reg_in, move_wdata_in, ext_data_in, reg_rdata_out;
  logic [7:0] move_rdata_out, ext_data_out, d, wd;
  logic busy_out, done_out, ext_data_oe_out, rd_n_out, wr_n_out, sel;
  logic [15:0] ext_addr_out;
  logic [15:0] dp [2];
  logic [3:0] wait_mc;
  logic [7:0] p2;
  int error_cnt = 0, tests_run = 0, cyc = 0, stretch = 1, wexp = 0;
  edast_ctrl i_edast_ctrl (.ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .move_req_in, .move_write_in, .move_indirect_in, .work_reg_in, .move_wdata_in,
    .busy_out, .done_out, .move_rdata_out, .wait_n_in, .ext_data_in, .ext_data_out, .ext_data_oe_out,
    .ext_addr_out, .rd_n_out, .wr_n_out);
  edast_ext_mem i_edast_ext_mem (.clk_in(ref_clk_in), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
    .addr_in(ext_addr_out), .data_in(ext_data_out), .wait_mc_in(wait_mc), .data_out(ext_data_in),
    .wait_n_out(wait_n_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge ref_clk_in);
    v = reg_rdata_out;
  endtask
  // One move; strobe width, length and address checked against values the bench works out itself
  task move(input logic w, input logic ind, input logic [7:0] v, output logic [7:0] r);
    int n, sw, bz;
    logic [15:0] ea;
    n = 0; sw = 0; bz = 0; ea = 16'h0000;
    @(posedge ref_clk_in);
    move_req_in <= 1'b1;
    move_write_in <= w;
    move_indirect_in <= ind;
    move_wdata_in <= v;
    @(posedge ref_clk_in);
    move_req_in <= 1'b0;
    while (done_out !== 1'b1 && n < 400) begin
      @(negedge ref_clk_in);
      n++;
      if (busy_out === 1'b1) bz++;
      if (rd_n_out === 1'b0 || wr_n_out === 1'b0) begin
        sw++;
        ea = ext_addr_out;
      end
    end
    r = move_rdata_out;
    chk(sw, (stretch == 0 ? 2 : 4 * stretch) + 4 * wexp);
    chk(bz, (2 + stretch + wexp) * 4);
    chk(ea, ind ? {p2, work_reg_in} : dp[sel]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_in, reg_wr_in, reg_rd_in, move_req_in, move_write_in, move_indirect_in} = 6'h20;
    {reg_addr_in, reg_wdata_in, work_reg_in, move_wdata_in} = 32'h0;
    wait_mc = 4'h0;
    p2 = 8'h00;
    void'($urandom(32'h5024));
    repeat (12) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rd(edast_pkg::OFS_CLOCK_CONTROL, d);
    chk(d[2:0], edast_pkg::STRETCH_RESET);
    rd(edast_pkg::OFS_POINTER_SELECT, d);
    chk(d, 8'h00);
    wr(edast_pkg::OFS_POINTER_SELECT, 8'hff);
    rd(edast_pkg::OFS_POINTER_SELECT, d);
    chk(d, 8'h01);
    dp[0] = $urandom;
    dp[1] = $urandom;
    wr(edast_pkg::OFS_DPTR0_LO, dp[0][7:0]);
    wr(edast_pkg::OFS_DPTR0_HI, dp[0][15:8]);
    wr(edast_pkg::OFS_SECOND_DATA_POINTER_LO, dp[1][7:0]);
    wr(edast_pkg::OFS_SECOND_DATA_POINTER_HI, dp[1][15:8]);
    for (int s = 0; s < 8; s++) begin
      wr(edast_pkg::OFS_CLOCK_CONTROL, 8'(s));
      stretch = s;
      sel = s[0];
      wr(edast_pkg::OFS_POINTER_SELECT, {7'h00, sel});
      wd = $urandom;
      move(1'b1, 1'b0, wd, d);
      move(1'b0, 1'b0, 8'h00, d);
      chk(d, wd);
      $display("test stretch %0d end", s);
    end
    p2 = $urandom;
    wr(edast_pkg::OFS_PORT2, p2);
    work_reg_in <= $urandom;
    move(1'b1, 1'b1, 8'h3c, d);
    $display("test indirect end");
    wait_mc = 4'h2;
    wr(edast_pkg::OFS_CLOCK_CONTROL, 8'h00);
    stretch = 0;
    wr(edast_pkg::OFS_MEMMAP_CONTROL, 8'h80);
    rd(edast_pkg::OFS_MEMMAP_CONTROL, d);
    chk(d[7], 1'b0);
    move(1'b0, 1'b0, 8'h00, d);
    wr(edast_pkg::OFS_TIMED_ACCESS, edast_pkg::TA_KEY1);
    wr(edast_pkg::OFS_TIMED_ACCESS, edast_pkg::TA_KEY2);
    wr(edast_pkg::OFS_MEMMAP_CONTROL, 8'h80);
    rd(edast_pkg::OFS_MEMMAP_CONTROL, d);
    chk(d[7], 1'b1);
    wexp = 2;
    move(1'b0, 1'b0, 8'h00, d);
    $display("test wait end");
    final_report();
  end
endmodule
